/* File: logic/hit_readout_formatter.sv */
// Readout, encoding, merging and block storage of card hit data.
// Assumes cards answer beats in order and decisions come one per block.
`default_nettype none
module hit_readout_formatter #(
  parameter int MEM_AW = 12,
  parameter int OFIFO_DEPTH = 128,
  parameter int TAG_DEPTH = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Trigger controller
  input wire logic first_level_accept,
  input wire logic second_level_accept,
  input wire logic second_level_discard,
  output logic trigger_error,
  // Configuration
  input wire logic fixed_mode,
  input wire logic [3:0] card_count,
  // Timing bus
  input wire logic rf_clk_level,
  output logic divided_reference_clock,
  output logic card_accept,
  // Readout bus
  input wire logic ro_valid,
  input wire readout_pkg::readout_beat_type ro_beat,
  output logic ro_ready,
  // DSP port
  input wire logic [MEM_AW-1:0] dsp_addr,
  output logic [15:0] dsp_data,
  // Third-level stream
  output logic l3_valid,
  output logic [15:0] l3_data,
  input wire logic l3_ready
);
  localparam int LAT = readout_pkg::ENC_LATENCY_CYC;
  localparam int OF_AW = $clog2(OFIFO_DEPTH);
  localparam int TG_AW = $clog2(TAG_DEPTH);
  // Room for everything still in the latency pipe
  localparam logic [OF_AW:0] OF_LIMIT = (OF_AW+1)'(OFIFO_DEPTH - LAT - 2);
  localparam logic [TG_AW:0] TG_LIMIT = (TG_AW+1)'(TAG_DEPTH - 1);

  function automatic logic [4:0] hit_count(input logic [15:0] w);
    logic [4:0] n;
    n = '0;
    for (int i = 0; i < 16; i++) begin
      n = n + 5'(w[i]);
    end
    return n;
  endfunction

  function automatic logic [3:0] lowest_hit(input logic [15:0] w);
    logic [3:0] idx;
    idx = '0;
    for (int i = 15; i >= 0; i--) begin
      if (w[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  logic rst_meta_r, rst_n_r;
  logic rf_last_r, ref_r, ref_rise, acc_pend_r, ev_pend_r;
  logic [2:0] rf_cnt_r;
  readout_pkg::rd_state_type rd_state_r;
  logic [3:0] exp_card_r, ncards_r;
  logic [1:0] beat_r;
  logic [readout_pkg::PACE_W-1:0] pace_r, pace_load;
  logic mode_fixed_r, take, ev_end, err_set, err_dec, ro_ready_r, err_r;
  logic [5:0] excess;
  logic [3:0] enc_idle, of_nempty, tag_nempty, tag_room, of_pop, tag_pop;
  logic [3:0][16:0] of_head;
  readout_pkg::tag_type [3:0] tag_head;
  readout_pkg::merge_state_type m_state_r, m_state_nxt;
  logic [1:0] m_sub_r, m_sub_nxt;
  logic [MEM_AW-1:0] m_base_r, m_base_nxt, wr_ptr_r, wr_ptr_nxt, wr_ptr_inc;
  logic [11:0] m_count_r, m_count_nxt;
  logic m_end_r, m_end_nxt, advance, hdr_done, mem_full, mem_we;
  logic [MEM_AW-1:0] mem_waddr, rd_ptr_r, l_addr_r;
  logic [15:0] mem_wdata, mem_a_data;
  readout_pkg::l3_state_type l_state_r;
  logic [12:0] left_r, hdr_len;
  logic iss_r, dv_r, room, l_consume, pend_v_r, pend_acc_r, new_dec;
  logic [2:0] occ;
  logic [MEM_AW:0] blocks_r;
  logic b0_v, b1_v, push, pop;
  logic [15:0] b0_d, b1_d;

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  assign ref_rise = (rf_clk_level != rf_last_r) && !ref_r &&
      (rf_cnt_r == 3'(readout_pkg::REF_DIV - 1));
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rf_last_r <= 1'b0;
      rf_cnt_r <= '0;
      ref_r <= 1'b0;
    end else begin
      rf_last_r <= rf_clk_level;
      if (rf_clk_level != rf_last_r) begin
        if (rf_cnt_r == 3'(readout_pkg::REF_DIV - 1)) begin
          rf_cnt_r <= '0;
          ref_r <= !ref_r;
        end else begin
          rf_cnt_r <= rf_cnt_r + 3'h1;
        end
      end
    end
  end

  // launched on rising edge, stable at falling
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      acc_pend_r <= 1'b0;
      ev_pend_r <= 1'b0;
      card_accept <= 1'b0;
    end else begin
      acc_pend_r <= first_level_accept || (acc_pend_r && !ref_rise);
      ev_pend_r <= (ref_rise && acc_pend_r) ||
          (ev_pend_r && rd_state_r != readout_pkg::RD_IDLE);
      if (ref_rise) begin
        card_accept <= acc_pend_r;
      end
    end
  end

  assign take = ro_valid && ro_ready_r;
  assign ev_end = beat_r == 2'(readout_pkg::LAST_BEAT) &&
      exp_card_r == ncards_r;

  // in sparse mode, excess hits lengthen the beat gap
  always_comb begin
    logic [4:0] hc;
    hc = '0;
    excess = '0;
    for (int k = 0; k < readout_pkg::SUBS; k++) begin
      hc = hit_count(ro_beat.hits[k*16 +: 16]);
      if (hc > 5'(readout_pkg::FREE_HITS)) begin
        excess = excess + 6'(hc - 5'(readout_pkg::FREE_HITS));
      end
    end
  end
  assign pace_load = mode_fixed_r ?
      10'(readout_pkg::FIXED_BEAT_CYC - 2) :
      10'(readout_pkg::SPARSE_BEAT_CYC - 2) +
      10'(excess) * 10'(readout_pkg::EXCESS_HIT_CYC);

  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rd_state_r <= readout_pkg::RD_IDLE;
      exp_card_r <= '0;
      ncards_r <= '0;
      beat_r <= '0;
      pace_r <= '0;
      mode_fixed_r <= 1'b0;
    end else begin
      unique case (rd_state_r)
        readout_pkg::RD_IDLE: begin
          if (ev_pend_r && card_count != 4'h0) begin
            rd_state_r <= readout_pkg::RD_READ;
            exp_card_r <= 4'(readout_pkg::FIRST_CARD);
            ncards_r <= card_count;
            beat_r <= '0;
            pace_r <= '0;
            mode_fixed_r <= fixed_mode;
          end
        end
        readout_pkg::RD_READ: begin
          if (take) begin
            pace_r <= pace_load;
            if (beat_r == 2'(readout_pkg::LAST_BEAT)) begin
              beat_r <= '0;
              exp_card_r <= exp_card_r + 4'h1;
              if (ev_end) begin
                rd_state_r <= readout_pkg::RD_IDLE;
              end
            end else begin
              beat_r <= beat_r + 2'h1;
            end
          end else if (pace_r != '0) begin
            pace_r <= pace_r - 10'h001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ro_ready_r <= 1'b0;
    end else begin
      ro_ready_r <= rd_state_r == readout_pkg::RD_READ && !take &&
          pace_r == '0 && (&enc_idle) && (&tag_room);
    end
  end
  assign ro_ready = ro_ready_r;

  assign err_set = (take && ro_beat.card != exp_card_r) ||
      (ro_valid && rd_state_r == readout_pkg::RD_IDLE) || err_dec;
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      err_r <= 1'b0;
    end else begin
      err_r <= err_set || (err_r && !first_level_accept);
    end
  end
  assign trigger_error = err_r;

  for (genvar k = 0; k < readout_pkg::SUBS; k++) begin : g_sub
    logic [15:0] work_r, word_in;
    logic busy_r, fix_r, last_hit, emit_ok, of_push;
    logic [2:0] drift_r;
    logic [3:0] card_r, grp_r, bit_idx;
    readout_pkg::hit_word_type hw;
    readout_pkg::enc_out_type enc_in;
    readout_pkg::enc_out_type pipe_r [LAT];
    logic [16:0] of_mem [OFIFO_DEPTH];
    logic [OF_AW-1:0] of_wp_r, of_rp_r;
    logic [OF_AW:0] of_cnt_r;
    readout_pkg::tag_type tag_mem [TAG_DEPTH];
    logic [TG_AW-1:0] tag_wp_r, tag_rp_r;
    logic [TG_AW:0] tag_cnt_r;

    assign word_in = ro_beat.hits[k*16 +: 16];
    assign bit_idx = lowest_hit(work_r);
    assign last_hit = (work_r & (work_r - 16'h0001)) == 16'h0000;
    assign emit_ok = busy_r && of_cnt_r <= OF_LIMIT;
    // lowest channel first within a word
    always_comb begin
      hw = '{spare: 1'b0, drift_time_field: drift_r,
          card_number_field: card_r, channel_number_field: {grp_r, bit_idx}};
      enc_in.valid = emit_ok;
      enc_in.last = fix_r || last_hit;
      // sparse mode emits one word per hit
      enc_in.word = fix_r ? work_r : hw;
    end

    always_ff @(posedge core_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
        work_r <= '0;
        busy_r <= 1'b0;
        fix_r <= 1'b0;
        drift_r <= '0;
        card_r <= '0;
        grp_r <= '0;
      end else if (take) begin
        work_r <= word_in;
        busy_r <= mode_fixed_r || word_in != 16'h0000;
        fix_r <= mode_fixed_r;
        drift_r <= ro_beat.drift[k*3 +: 3];
        card_r <= ro_beat.card;
        grp_r <= {beat_r, 2'(k)};
      end else if (emit_ok) begin
        busy_r <= !(fix_r || last_hit);
        work_r <= work_r & (work_r - 16'h0001);
      end
    end
    assign enc_idle[k] = !busy_r;

    always_ff @(posedge core_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
        for (int i = 0; i < LAT; i++) begin
          pipe_r[i] <= '0;
        end
      end else begin
        pipe_r[0] <= enc_in;
        for (int i = 1; i < LAT; i++) begin
          pipe_r[i] <= pipe_r[i-1];
        end
      end
    end

    assign of_push = pipe_r[LAT-1].valid;
    always_ff @(posedge core_clk) begin
      if (of_push) begin
        of_mem[of_wp_r] <= {pipe_r[LAT-1].last, pipe_r[LAT-1].word};
      end
      if (take) begin
        tag_mem[tag_wp_r] <= '{event_end: ev_end,
            nonempty: mode_fixed_r || word_in != 16'h0000};
      end
    end
    always_ff @(posedge core_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
        of_wp_r <= '0;
        of_rp_r <= '0;
        of_cnt_r <= '0;
        tag_wp_r <= '0;
        tag_rp_r <= '0;
        tag_cnt_r <= '0;
      end else begin
        of_wp_r <= of_wp_r + OF_AW'(of_push);
        of_rp_r <= of_rp_r + OF_AW'(of_pop[k]);
        of_cnt_r <= of_cnt_r + (OF_AW+1)'(of_push) - (OF_AW+1)'(of_pop[k]);
        tag_wp_r <= tag_wp_r + TG_AW'(take);
        tag_rp_r <= tag_rp_r + TG_AW'(tag_pop[k]);
        tag_cnt_r <= tag_cnt_r + (TG_AW+1)'(take) - (TG_AW+1)'(tag_pop[k]);
      end
    end
    assign of_nempty[k] = of_cnt_r != '0;
    assign of_head[k] = of_mem[of_rp_r];
    assign tag_nempty[k] = tag_cnt_r != '0;
    assign tag_head[k] = tag_mem[tag_rp_r];
    assign tag_room[k] = tag_cnt_r < TG_LIMIT;
  end

  assign wr_ptr_inc = wr_ptr_r + 1'b1;
  assign mem_full = wr_ptr_inc == rd_ptr_r;

  always_comb begin
    m_state_nxt = m_state_r;
    m_sub_nxt = m_sub_r;
    m_base_nxt = m_base_r;
    wr_ptr_nxt = wr_ptr_r;
    m_count_nxt = m_count_r;
    m_end_nxt = m_end_r;
    mem_we = 1'b0;
    mem_waddr = wr_ptr_r;
    mem_wdata = of_head[m_sub_r][15:0];
    of_pop = '0;
    tag_pop = '0;
    advance = 1'b0;
    hdr_done = 1'b0;
    unique case (m_state_r)
      readout_pkg::M_IDLE: begin
        if (tag_nempty[0] && !mem_full) begin
          m_base_nxt = wr_ptr_r;
          wr_ptr_nxt = wr_ptr_inc;
          m_count_nxt = readout_pkg::COUNT_RESET;
          m_sub_nxt = '0;
          m_end_nxt = 1'b0;
          m_state_nxt = readout_pkg::M_TAG;
        end
      end
      readout_pkg::M_TAG: begin
        if (tag_nempty[m_sub_r]) begin
          tag_pop[m_sub_r] = 1'b1;
          if (m_sub_r == 2'h3) begin
            m_end_nxt = tag_head[m_sub_r].event_end;
          end
          if (tag_head[m_sub_r].nonempty) begin
            m_state_nxt = readout_pkg::M_DRAIN;
          end else begin
            advance = 1'b1;
          end
        end
      end
      readout_pkg::M_DRAIN: begin
        if (of_nempty[m_sub_r] && !mem_full) begin
          of_pop[m_sub_r] = 1'b1;
          mem_we = 1'b1;
          wr_ptr_nxt = wr_ptr_inc;
          m_count_nxt = m_count_r + 12'h001;
          advance = of_head[m_sub_r][16];
        end
      end
      readout_pkg::M_HDR: begin
        mem_we = 1'b1;
        mem_waddr = m_base_r;
        mem_wdata = readout_pkg::header_word_type'{spare: 4'h0,
            word_count_field: m_count_r};
        hdr_done = 1'b1;
        m_state_nxt = readout_pkg::M_IDLE;
      end
    endcase
    if (advance) begin
      m_sub_nxt = m_sub_r + 2'h1;
      m_state_nxt = (m_sub_r == 2'h3 && m_end_nxt) ?
          readout_pkg::M_HDR : readout_pkg::M_TAG;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      m_state_r <= readout_pkg::M_IDLE;
      m_sub_r <= '0;
      m_base_r <= '0;
      wr_ptr_r <= '0;
      m_count_r <= readout_pkg::COUNT_RESET;
      m_end_r <= 1'b0;
    end else begin
      m_state_r <= m_state_nxt;
      m_sub_r <= m_sub_nxt;
      m_base_r <= m_base_nxt;
      wr_ptr_r <= wr_ptr_nxt;
      m_count_r <= m_count_nxt;
      m_end_r <= m_end_nxt;
    end
  end

  dual_port_store #(.AW(MEM_AW), .DW(16)) store (
    .core_clk(core_clk),
    .rst_n(rst_n_r),
    .wr_en(mem_we),
    .wr_addr(mem_waddr),
    .wr_data(mem_wdata),
    .a_addr(l_addr_r),
    .a_data(mem_a_data),
    .b_addr(dsp_addr),
    .b_data(dsp_data)
  );

  // one pending decision, extra ones flagged
  assign new_dec = second_level_accept || second_level_discard;
  assign err_dec = (new_dec && pend_v_r && !l_consume) ||
      (second_level_accept && second_level_discard);
  assign hdr_len = {1'b0, mem_a_data[11:0]} + 13'h0001;
  assign l_consume =
      (l_state_r == readout_pkg::L_HDR && dv_r && !pend_acc_r) ||
      (l_state_r == readout_pkg::L_RUN && left_r == '0 && !iss_r && !dv_r);
  assign occ = 3'(b0_v) + 3'(b1_v) + 3'(iss_r) + 3'(dv_r);
  assign room = occ < 3'h2;

  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pend_v_r <= 1'b0;
      pend_acc_r <= 1'b0;
      blocks_r <= '0;
    end else begin
      pend_v_r <= new_dec || (pend_v_r && !l_consume);
      if (new_dec && !(pend_v_r && !l_consume)) begin
        pend_acc_r <= second_level_accept && !second_level_discard;
      end
      blocks_r <= blocks_r + (MEM_AW+1)'(hdr_done) - (MEM_AW+1)'(l_consume);
    end
  end

  // send or skip the oldest block
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      l_state_r <= readout_pkg::L_IDLE;
      rd_ptr_r <= '0;
      l_addr_r <= '0;
      left_r <= '0;
      iss_r <= 1'b0;
      dv_r <= 1'b0;
    end else begin
      iss_r <= 1'b0;
      dv_r <= iss_r;
      unique case (l_state_r)
        readout_pkg::L_IDLE: begin
          if (blocks_r != '0 && pend_v_r) begin
            l_addr_r <= rd_ptr_r;
            iss_r <= 1'b1;
            l_state_r <= readout_pkg::L_HDR;
          end
        end
        readout_pkg::L_HDR: begin
          if (dv_r && pend_acc_r) begin
            left_r <= hdr_len;
            l_state_r <= readout_pkg::L_RUN;
          end else if (dv_r) begin
            rd_ptr_r <= rd_ptr_r + MEM_AW'(hdr_len);
            l_state_r <= readout_pkg::L_IDLE;
          end
        end
        readout_pkg::L_RUN: begin
          if (left_r != '0 && room) begin
            l_addr_r <= rd_ptr_r;
            rd_ptr_r <= rd_ptr_r + 1'b1;
            left_r <= left_r - 13'h0001;
            iss_r <= 1'b1;
          end else if (l_consume) begin
            l_state_r <= readout_pkg::L_IDLE;
          end
        end
      endcase
    end
  end

  // Two-entry buffer so a stalled receiver loses nothing
  assign push = dv_r && l_state_r == readout_pkg::L_RUN;
  assign pop = b0_v && l3_ready;
  always_ff @(posedge core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      b0_v <= 1'b0;
      b1_v <= 1'b0;
      b0_d <= '0;
      b1_d <= '0;
    end else begin
      if (pop) begin
        b0_d <= b1_d;
        b0_v <= b1_v;
        b1_v <= 1'b0;
      end
      if (push && (!b0_v || (pop && !b1_v))) begin
        b0_d <= mem_a_data;
        b0_v <= 1'b1;
      end else if (push) begin
        b1_d <= mem_a_data;
        b1_v <= 1'b1;
      end
    end
  end
  assign l3_valid = b0_v;
  assign l3_data = b0_d;
  assign divided_reference_clock = ref_r;
endmodule
`default_nettype wire

/* File: logic/readout_pkg.sv */
// Constants and types shared by the hit readout formatter and its bench.
// Assumes a single 200 MHz core clock and pin inputs synchronous to it.
// Functional notes
// - Sparse mode: one word per hit only
// - Fixed mode: every channel as one bit
// - Word count header ahead of block data
// - Four 16-bit substreams, one encoder each
// - Encoder latency of 300 ns
// - Sparse 80 Mbyte/s below six hits/word
// - Each excess hit pauses readout 50 ns
// - Encoders push into strobed output FIFOs
// - Tag FIFO marks non-empty words per substream
// - Merge sequencer combines substreams into memory
// - Sparse hits appear in ascending order
// - Sparse count up to cards times 192
// - Fixed: no suppression, count is cards times 12
// - Fixed rate occupancy independent, 900 ns/card
// - Sparse word: drift, card, channel fields
// - Fixed: twelve words per card, ascending
// - Read up to 15 cards over backplane
// - Forward first-level accept to all cards
// - Check read data, report errors upward
// - Distribute reference, cards sample on falling
// - Second level: send on accept, drop otherwise
`default_nettype none
package readout_pkg;
  localparam int CLK_NS = 5;
  localparam int SUBS = 4;
  localparam int WORD_W = 16;
  localparam int MAX_CARDS = 15;
  localparam int BEATS_PER_CARD = 3;
  localparam int WORDS_PER_CARD = 12;
  localparam int SPARSE_WORDS_PER_CARD = 192;
  localparam int FREE_HITS = 5;
  localparam int REF_DIV = 7;
  localparam int ENC_LATENCY_NS = 300;
  localparam int ENC_LATENCY_CYC = (ENC_LATENCY_NS + CLK_NS - 1) / CLK_NS;
  // 8 bytes per beat at 80 Mbyte/s
  localparam int SPARSE_BEAT_NS = 100;
  localparam int SPARSE_BEAT_CYC = (SPARSE_BEAT_NS + CLK_NS - 1) / CLK_NS;
  localparam int EXCESS_HIT_NS = 50;
  localparam int EXCESS_HIT_CYC = (EXCESS_HIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int FIXED_CARD_NS = 900;
  localparam int FIXED_BEAT_CYC = (FIXED_CARD_NS + BEATS_PER_CARD * CLK_NS - 1)
      / (BEATS_PER_CARD * CLK_NS);
  localparam int PACE_W = 10;
  localparam int FIRST_CARD = 1;
  localparam int LAST_BEAT = BEATS_PER_CARD - 1;
  localparam logic [11:0] COUNT_RESET = 12'h000;

  typedef enum {RD_IDLE, RD_READ} rd_state_type;
  typedef enum {M_IDLE, M_TAG, M_DRAIN, M_HDR} merge_state_type;
  typedef enum {L_IDLE, L_HDR, L_RUN} l3_state_type;

  typedef struct packed {
    logic [3:0] card;
    logic [11:0] drift;
    logic [63:0] hits;
  } readout_beat_type;

  typedef struct packed {
    logic spare;
    logic [2:0] drift_time_field;
    logic [3:0] card_number_field;
    logic [7:0] channel_number_field;
  } hit_word_type;

  typedef struct packed {
    logic [3:0] spare;
    logic [11:0] word_count_field;
  } header_word_type;

  typedef struct packed {
    logic valid;
    logic last;
    logic [15:0] word;
  } enc_out_type;

  typedef struct packed {
    logic event_end;
    logic nonempty;
  } tag_type;
endpackage
`default_nettype wire

/* File: logic/dual_port_store.sv */
// Block store shared by the merge writer, third-level reader and DSP.
// Assumes one clock; a read in the write cycle returns the old word.
`default_nettype none
module dual_port_store #(
  parameter int AW = 12,
  parameter int DW = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  // Read port A
  input wire logic [AW-1:0] a_addr,
  output logic [DW-1:0] a_data,
  // Read port B
  input wire logic [AW-1:0] b_addr,
  output logic [DW-1:0] b_data
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered reads keep both consumers off the array timing
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      a_data <= '0;
      b_data <= '0;
    end else begin
      a_data <= mem[a_addr];
      b_data <= mem[b_addr];
    end
  end
endmodule
`default_nettype wire

/* File: tb/hit_readout_formatter_monitor.sv */
// Port checker for the hit readout formatter.
// Assumes rf_clk_level toggles every two core clocks.
`default_nettype none
module formatter_port_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Trigger side
  input wire logic first_level_accept,
  input wire logic second_level_accept,
  input wire logic second_level_discard,
  input wire logic trigger_error,
  // Timing and readout
  input wire logic divided_reference_clock,
  input wire logic card_accept,
  input wire logic ro_valid,
  input wire logic ro_ready,
  // Third-level stream
  input wire logic l3_valid,
  input wire logic [15:0] l3_data,
  input wire logic l3_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_take; ro_valid && ro_ready |=> !ro_ready [*8]; endproperty
  a_take: assert property (p_take)
    else $error("ready back too soon after a take");
  property p_fwd; first_level_accept |-> ##[0:60] card_accept; endproperty
  a_fwd: assert property (p_fwd)
    else $error("accept not forwarded to cards");
  property p_hold; $rose(card_accept) |=> card_accept [*8]; endproperty
  a_hold: assert property (p_hold)
    else $error("card accept too short");
  property p_sync;
    $changed(card_accept) |-> $rose(divided_reference_clock);
  endproperty
  a_sync: assert property (p_sync)
    else $error("card accept off the reference edge");
  property p_ref;
    $changed(divided_reference_clock) |=>
      $stable(divided_reference_clock) [*8];
  endproperty
  a_ref: assert property (p_ref)
    else $error("reference half period too short");
  property p_err;
    trigger_error && !first_level_accept |=> trigger_error;
  endproperty
  a_err: assert property (p_err)
    else $error("error flag dropped on its own");
  property p_both;
    second_level_accept && second_level_discard |-> ##[1:3] trigger_error;
  endproperty
  a_both: assert property (p_both)
    else $error("double decision not flagged");
  property p_l3;
    l3_valid && !l3_ready |=> l3_valid && $stable(l3_data);
  endproperty
  a_l3: assert property (p_l3)
    else $error("stream word changed before taken");
endmodule
`default_nettype wire

/* File: tb/readout_cards.sv */
// Card crate model on the readout bus.
// Assumes one beat offered at a time, held until taken.
`default_nettype none
module readout_cards (
  // Clock
  input wire logic core_clk,
  // Bench control
  input wire logic [3:0] card_count,
  input wire logic heavy,
  input wire logic bad,
  input wire logic slow,
  // Timing and readout bus
  input wire logic card_accept,
  input wire logic ref_clk,
  input wire logic ro_ready,
  output logic ro_valid,
  output readout_pkg::readout_beat_type ro_beat
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy = 0;
  logic acc_q = 0;
  logic acc_s = 0;
  logic [3:0] card = 4'h1;
  logic [1:0] beat = 2'h0;
  logic [4:0] lag = 5'h00;
  initial ro_valid = 0;
  initial ro_beat = '0;
  always @(negedge ref_clk) acc_s <= card_accept;
  always @(posedge core_clk) begin
    acc_q <= acc_s;
    lag <= lag + 5'h01;
    if (acc_s && !acc_q) begin
      busy <= 1;
      card <= 4'h1;
      beat <= 2'h0;
    end else if (ro_valid && ro_ready) begin
      ro_valid <= 0;
      // Released bus shows the inverse
      ro_beat <= ~ro_beat;
      lag <= 5'h00;
      beat <= (beat == 2'h2) ? 2'h0 : beat + 2'h1;
      if (beat == 2'h2)
        card <= card + 4'h1;
      if (beat == 2'h2 && card == card_count)
        busy <= 0;
    end else if (busy && !ro_valid && (!slow || lag[4])) begin
      ro_valid <= 1;
      ro_beat.card <= bad ? card + 4'h1 : card;
      ro_beat.drift <= 12'h6b1;
      for (int k = 0; k < 4; k++)
        ro_beat.hits[16*k+:16] <= heavy ? 16'h7f00 :
            16'h0001 << 4'(card + beat + 4'(k));
    end
  end
endmodule
`default_nettype wire

/* File: tb/hit_readout_formatter_tb.sv */
// Bench for the hit readout formatter with a card crate model.
// Assumes the port checker bound at the foot of this file.
`default_nettype none
module hit_readout_formatter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, reset_n = 0, fla = 0, sla = 0, sld = 0, rf = 0;
  logic fixed_mode = 0, heavy = 0, bad = 0, slow = 0, l3_ready = 0;
  logic ro_valid, ro_ready, trigger_error, l3_valid, card_accept, dref;
  logic [3:0] card_count = 4'h1;
  logic [11:0] dsp_addr = 12'h000;
  logic [15:0] dsp_data, l3_data;
  readout_pkg::readout_beat_type ro_beat;
  int n_mismatch = 0, n_compared = 0, cyc = 0, last_t, gap, n_take;
  logic [15:0] exp_q[$];
  always #2.5 core_clk = ~core_clk;
  always @(negedge core_clk) begin
    cyc++;
    if (cyc % 2 == 0)
      rf <= ~rf;
  end
  always @(posedge core_clk)
    if (ro_valid && ro_ready) begin
      if (last_t > 0 && cyc - last_t < gap)
        gap = cyc - last_t;
      last_t = cyc;
      n_take++;
    end
  hit_readout_formatter u_dut (.core_clk, .reset_n,
    .first_level_accept(fla), .second_level_accept(sla),
    .second_level_discard(sld), .trigger_error, .fixed_mode, .card_count,
    .rf_clk_level(rf), .divided_reference_clock(dref), .card_accept,
    .ro_valid, .ro_beat, .ro_ready, .dsp_addr, .dsp_data, .l3_valid,
    .l3_data, .l3_ready);
  readout_cards u_cards (.core_clk, .card_count, .heavy, .bad, .slow,
    .card_accept, .ref_clk(dref), .ro_ready, .ro_valid, .ro_beat);
  task automatic report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic run_ev(input logic fm, input logic [3:0] n,
                        input logic hv, input int lim);
    logic [15:0] w;
    logic [11:0] dr;
    dr = 12'h6b1;
    exp_q = {};
    for (int c = 1; c <= n; c++)
      for (int b = 0; b < 3; b++)
        for (int k = 0; k < 4; k++) begin
          w = hv ? 16'h7f00 : 16'h0001 << 4'(c + b + k);
          if (fm)
            exp_q.push_back(w);
          else
            for (int j = 0; j < 16; j++)
              if (w[j])
                exp_q.push_back({1'b0, dr[3*k+:3], 4'(c), 8'(64*b+16*k+j)});
        end
    exp_q.push_front({4'h0, 12'(exp_q.size())});
    fixed_mode = fm;
    card_count = n;
    heavy = hv;
    gap = 9999;
    last_t = 0;
    n_take = 0;
    fla = 1;
    @(negedge core_clk) fla = 0;
    for (int i = 0; i < 20000 && n_take < 3 * n; i++)
      @(negedge core_clk);
    if (n_take < 3 * n) begin
      n_mismatch++;
      report_and_stop();
    end
    cmp({15'h0, gap >= lim}, 16'h0001);
  endtask
  task automatic decide(input logic a, input logic d);
    sla = a;
    sld = d;
    @(negedge core_clk);
    sla = 0;
    sld = 0;
  endtask
  task automatic collect;
    logic [15:0] got[$];
    // Receiver stalls every other cycle
    for (int i = 0; i < 5000 && got.size() < exp_q.size(); i++) begin
      @(negedge core_clk) l3_ready = ~l3_ready;
      @(posedge core_clk) if (l3_valid && l3_ready) got.push_back(l3_data);
    end
    @(negedge core_clk) l3_ready = 0;
    if (got.size() < exp_q.size()) begin
      n_mismatch++;
      report_and_stop();
    end
    foreach (exp_q[j])
      cmp(got[j], exp_q[j]);
  endtask
  initial begin
    repeat (20) @(negedge core_clk);
    reset_n = 1;
    repeat (5) @(negedge core_clk);
    run_ev(0, 4'hf, 0, 20);
    decide(1, 0);
    collect();
    cmp(dsp_data, exp_q[0]);
    $display("test sparse done");
    run_ev(1, 4'h3, 0, 60);
    decide(1, 0);
    collect();
    $display("test fixed done");
    run_ev(0, 4'h1, 1, 100);
    decide(0, 1);
    repeat (300) @(negedge core_clk);
    slow = 1;
    run_ev(0, 4'h2, 0, 20);
    decide(1, 0);
    collect();
    cmp({15'h0, trigger_error}, 16'h0000);
    $display("test discard done");
    bad = 1;
    run_ev(0, 4'h1, 0, 20);
    bad = 0;
    repeat (100) @(negedge core_clk);
    cmp({15'h0, trigger_error}, 16'h0001);
    decide(1, 1);
    repeat (300) @(negedge core_clk);
    run_ev(0, 4'h1, 0, 20);
    cmp({15'h0, trigger_error}, 16'h0000);
    decide(0, 1);
    $display("test error done");
    report_and_stop();
  end
endmodule
bind hit_readout_formatter formatter_port_checker u_mon (.core_clk,
  .reset_n, .first_level_accept, .second_level_accept,
  .second_level_discard, .trigger_error, .divided_reference_clock,
  .card_accept, .ro_valid, .ro_ready, .l3_valid, .l3_data, .l3_ready);
`default_nettype wire
